// file: hw/clocked_fifo_reset_port_a.sv
// Reset sequencing, flag control and port A drive of the clocked FIFO
`timescale 1ns/100ps
module clocked_fifo_reset_port_a
  import fifo_reset_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_a_clock,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_write_read,
  input wire logic port_a_enable,
  input wire logic flag_select_0,
  input wire logic flag_select_1,
  input wire logic [DATA_W-1:0] port_a_data_in,
  output logic [DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe_n,
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic mailbox1_flag_n,
  output logic mailbox2_flag_n,
  output logic [OFFSET_W-1:0] flagOffset,
  output logic [DATA_W-1:0] readData,
  output logic readValid,
  input wire logic readReady
);
  // Pin synchroniser: stage 1 feeds stage 2 only, stages 2 and 3 vote
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1_q, pinS2_q, pinS3_q;
  logic [PIN_W-1:0] pinStable_q, pinStable_d; // Last value on which stages 2 and 3 agreed
  // Reset sequencing state
  logic [1:0] aEdgeCount_q, aEdgeCount_d; // Port A edges since release, saturating
  logic loadPending_q, loadPending_d; // Set by reset, cleared by the offset load
  logic [OFFSET_W-1:0] offset_q, offset_d;
  logic [OFFSET_W-1:0] offsetSel;
  // Flag and port A output registers
  logic full_q, full_d;
  logic empty_q, empty_d;
  logic almostEmpty_q, almostEmpty_d;
  logic almostFull_q, almostFull_d;
  logic mailbox_q, mailbox_d;
  logic oeN_q, oeN_d;
  logic [DATA_W-1:0] aOut_q, aOut_d;
  // Buffer hookup
  logic aRise, writeStrobe, bufInReady;
  logic [COUNT_W-1:0] bufCount;
  logic [DATA_W-1:0] bufOutData;

  assign pinRaw = {port_a_data_in, flag_select_1, flag_select_0, port_a_enable,
                   port_a_write_read, port_a_chip_select_n, port_a_clock};

  // Synchroniser flops carry no reset so the flag selects are live at release
  always_ff @(posedge clk) begin
    pinS1_q <= pinRaw;
    pinS2_q <= pinS1_q;
    pinS3_q <= pinS2_q;
  end

  // A pin change counts only once the last two stages agree
  always_comb begin
    pinStable_d = (pinS2_q & pinS3_q) | (pinStable_q & (pinS2_q | pinS3_q));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinStable_q <= '0;
      pinStable_q[PIN_PORT_A_CLOCK] <= PORT_A_CLOCK_STABLE_RESET;
      pinStable_q[PIN_CS_N] <= 1'b1;
    end else begin
      pinStable_q <= pinStable_d;
    end
  end

  // Rising port A clock seen in the system clock domain
  assign aRise = pinStable_d[PIN_PORT_A_CLOCK] & ~pinStable_q[PIN_PORT_A_CLOCK];

  // Offset chosen by the two flag selects, taken from the vote of stages 2 and 3.
  // The vote is read before its register so that the first edge after release already
  // sees the settled selects rather than the reset value of the stable register.
  always_comb begin
    case ({pinStable_d[PIN_FS1], pinStable_d[PIN_FS0]})
      2'b11: offsetSel = OFFSET_SEL_11;
      2'b10: offsetSel = OFFSET_SEL_10;
      2'b01: offsetSel = OFFSET_SEL_01;
      default: offsetSel = OFFSET_SEL_00;
    endcase
  end

  // Words enter on a port A edge while selected for writing and not full
  assign writeStrobe = aRise & ~pinStable_q[PIN_CS_N] & pinStable_q[PIN_WR] &
                       pinStable_q[PIN_EN] & full_q;

  two_entry_buffer u_buffer (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(writeStrobe),
    .inReady(bufInReady),
    .inData(pinStable_q[PIN_DATA +: DATA_W]),
    .outValid(readValid),
    .outReady(readReady),
    .outData(bufOutData),
    .count(bufCount)
  );
  assign readData = bufOutData;

  // Reset sequence: count port A edges, load the offset once per release
  always_comb begin
    aEdgeCount_d = aEdgeCount_q;
    if (aRise && (aEdgeCount_q != FULL_RELEASE_EDGES)) begin
      aEdgeCount_d = aEdgeCount_q + 2'h1;
    end
    loadPending_d = 1'b0;
    offset_d = offset_q;
    if (loadPending_q) begin
      offset_d = offsetSel;
    end
  end

  // Flags track the buffer once the release sequence is done
  always_comb begin
    full_d = (aEdgeCount_q == FULL_RELEASE_EDGES) & bufInReady;
    empty_d = (bufCount != 2'h0);
    almostEmpty_d = (bufCount == COUNT_W'(BUF_DEPTH));
    almostFull_d = (bufCount != COUNT_W'(BUF_DEPTH));
    mailbox_d = MAILBOX_RESET_N; // Mail path lives elsewhere; flags stay idle
    // Drive only while selected and set for reading
    oeN_d = pinStable_q[PIN_CS_N] | pinStable_q[PIN_WR];
    aOut_d = bufOutData;
  end

  // Asynchronous reset: no clock alignment needed to enter or leave it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aEdgeCount_q <= 2'h0;
      loadPending_q <= 1'b1;
      offset_q <= OFFSET_RESET;
      full_q <= FULL_RESET_N;
      empty_q <= EMPTY_RESET_N;
      almostEmpty_q <= ALMOST_EMPTY_RESET_N;
      almostFull_q <= ALMOST_FULL_RESET_N;
      mailbox_q <= MAILBOX_RESET_N;
      oeN_q <= 1'b1;
      aOut_q <= '0;
    end else begin
      aEdgeCount_q <= aEdgeCount_d;
      loadPending_q <= loadPending_d;
      offset_q <= offset_d;
      full_q <= full_d;
      empty_q <= empty_d;
      almostEmpty_q <= almostEmpty_d;
      almostFull_q <= almostFull_d;
      mailbox_q <= mailbox_d;
      oeN_q <= oeN_d;
      aOut_q <= aOut_d;
    end
  end

  assign full_flag_n = full_q;
  assign empty_flag_n = empty_q;
  assign almost_empty_n = almostEmpty_q;
  assign almost_full_n = almostFull_q;
  assign mailbox1_flag_n = mailbox_q;
  assign mailbox2_flag_n = mailbox_q;
  assign flagOffset = offset_q;
  assign port_a_data_oe_n = oeN_q;
  assign port_a_data_out = aOut_q;

  // Flags show reset levels at any edge while reset is low
  a_reset_async: assert property (@(posedge clk) !reset_n |->
    (!full_flag_n && !empty_flag_n && !almost_empty_n && almost_full_n))
    else $error("flags not at reset levels while reset held");

  // First edge after release still shows cleared pointers and reset flags
  a_reset_flags: assert property (@(posedge clk) $rose(reset_n) |->
    (bufCount == 2'h0 && !full_flag_n && !almost_empty_n && almost_full_n))
    else $error("pointers or flags not cleared at release");

  // Pointers stay cleared and nothing is offered for reading while reset is held
  a_buffer_cleared: assert property (@(posedge clk) !reset_n |->
    (bufCount == 2'h0 && !readValid))
    else $error("buffer not emptied while reset held");

  a_mailbox_idle: assert property (@(posedge clk) !reset_n |->
    (mailbox1_flag_n && mailbox2_flag_n))
    else $error("mailbox flags not high under reset");

  // Full flag may rise only after two counted port A edges
  a_full_release: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(full_flag_n) |-> $past(aEdgeCount_q) == FULL_RELEASE_EDGES)
    else $error("full flag rose before two port A edges");

  a_full_after_two: assert property (@(posedge clk) disable iff (!reset_n)
    (aEdgeCount_q == FULL_RELEASE_EDGES && bufCount == 2'h0) |=> full_flag_n)
    else $error("full flag stayed low after two port A edges");

  a_offset_load: assert property (@(posedge clk) disable iff (!reset_n)
    loadPending_q |=> (flagOffset == $past(offsetSel) && !loadPending_q))
    else $error("offset not loaded at reset release");

  a_offset_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !loadPending_q |=> $stable(flagOffset))
    else $error("offset changed without a reset release");

  a_port_float: assert property (@(posedge clk) disable iff (!reset_n)
    (pinStable_q[PIN_CS_N] || pinStable_q[PIN_WR]) |=> port_a_data_oe_n)
    else $error("port A driven while deselected");

  a_port_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (!pinStable_q[PIN_CS_N] && !pinStable_q[PIN_WR]) |=> !port_a_data_oe_n)
    else $error("port A not driven while selected for read");
endmodule // clocked_fifo_reset_port_a

// file: hw/fifo_reset_pkg.sv
// Shared constants for the FIFO reset and port A control block
package fifo_reset_pkg;
  // Data path width and buffer depth
  localparam int DATA_W = 36;
  localparam int BUF_DEPTH = 2;
  localparam int COUNT_W = 2;
  // Almost-flag offset width and the values chosen by the two select pins
  localparam int OFFSET_W = 5;
  localparam logic [OFFSET_W-1:0] OFFSET_SEL_11 = 5'h10; // Both selects high
  localparam logic [OFFSET_W-1:0] OFFSET_SEL_10 = 5'h0c; // Select 1 high only
  localparam logic [OFFSET_W-1:0] OFFSET_SEL_01 = 5'h08; // Select 0 high only
  localparam logic [OFFSET_W-1:0] OFFSET_SEL_00 = 5'h04; // Both low, plain default
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 5'h00;
  // Port A clock edges after release before the full flag may rise
  localparam logic [1:0] FULL_RELEASE_EDGES = 2'h2;
  // Positions of the pin inputs inside the synchroniser vector
  localparam int PIN_PORT_A_CLOCK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_WR = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_FS0 = 4;
  localparam int PIN_FS1 = 5;
  localparam int PIN_DATA = 6;
  localparam int PIN_W = PIN_DATA + DATA_W;
  // Flag levels forced while reset is held
  localparam logic FULL_RESET_N = 1'b0;
  localparam logic EMPTY_RESET_N = 1'b0;
  localparam logic ALMOST_EMPTY_RESET_N = 1'b0;
  localparam logic ALMOST_FULL_RESET_N = 1'b1;
  localparam logic MAILBOX_RESET_N = 1'b1;
  // Reset level of the edge tracker, high so a clock already high at release is no edge
  localparam logic PORT_A_CLOCK_STABLE_RESET = 1'b1;
endpackage

// file: hw/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides and registered outputs
`timescale 1ns/100ps
module two_entry_buffer
  import fifo_reset_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [DATA_W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [DATA_W-1:0] outData,
  output logic [COUNT_W-1:0] count
);
  logic [DATA_W-1:0] head_q, head_d; // Oldest word, seen at the output
  logic [DATA_W-1:0] tail_q, tail_d; // Second word
  logic [COUNT_W-1:0] count_q, count_d; // Words held
  logic valid_q, valid_d; // Registered copy of count above zero
  logic push, pop;

  assign inReady = (count_q != COUNT_W'(BUF_DEPTH));
  assign push = inValid & inReady;
  assign pop = valid_q & outReady;
  assign outValid = valid_q;
  assign outData = head_q;
  assign count = count_q;

  // Next contents; a full buffer takes no word, even in the cycle it drains one
  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    count_d = count_q;
    case ({push, pop})
      2'b10: begin
        if (count_q == 2'h0) begin
          head_d = inData;
        end else begin
          tail_d = inData;
        end
        count_d = count_q + 2'h1;
      end
      2'b01: begin
        head_d = tail_q;
        count_d = count_q - 2'h1;
      end
      2'b11: begin
        // Count stays; the new word lands behind whatever remains
        if (count_q == 2'h1) begin
          head_d = inData;
        end else begin
          head_d = tail_q;
          tail_d = inData;
        end
      end
      default: begin
        count_d = count_q;
      end
    endcase
    valid_d = (count_d != 2'h0);
  end

  // Storage and pointers; reset empties the buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      head_q <= '0;
      tail_q <= '0;
      count_q <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      count_q <= count_d;
      valid_q <= valid_d;
    end
  end
endmodule // two_entry_buffer

// file: verification/port_a_host.sv
// Port A controller model: drives the pins for one write frame or one static pin setting
`timescale 1ns/100ps
module port_a_host
  import fifo_reset_pkg::*;
(
  input wire logic clk,
  input wire logic start,
  input wire logic pulse,
  input wire logic csN,
  input wire logic wr,
  input wire logic en,
  input wire logic [DATA_W-1:0] word,
  output logic pinClock,
  output logic pinCsN,
  output logic pinWr,
  output logic pinEn,
  output logic [DATA_W-1:0] pinData,
  output logic done
);
  logic [4:0] step; // Frame phase, zero while idle
  // Quiet pins at time zero; the clock stands still low outside frames
  initial begin
    {pinClock, pinWr, pinEn, done, step} = '0;
    pinCsN = 1'b1;
    pinData = '0;
  end
  // Pins change only after an edge and hold six cycles before the port clock rises and six after it falls
  always @(posedge clk) begin
    done <= 1'b0;
    if (start) begin
      {pinCsN, pinWr, pinEn, pinData} <= {csN, wr, en, word};
      step <= pulse ? 5'h01 : 5'h00;
      done <= !pulse;
    end else if (step != 5'h00) begin
      step <= step + 5'h01;
      if (step == 5'h06) pinClock <= 1'b1; // Setup well above the three-flop sync
      if (step == 5'h0c) pinClock <= 1'b0;
      if (step == 5'h12) begin
        // Released data shows the inverse so a stale word is never mistaken for valid
        {step, done, pinEn} <= {5'h00, 1'b1, 1'b0};
        pinData <= ~pinData;
      end
    end
  end
endmodule // port_a_host

// file: verification/tb.sv
// Self-checking testbench for the FIFO reset and port A control block
`timescale 1ns/100ps
module tb;
  import fifo_reset_pkg::*;
  logic clk = 0, reset_n = 1, start = 0, pulse = 0, csN = 1, wr = 0, en = 0;
  logic fs0 = 0, fs1 = 0, readReady = 0;
  logic [DATA_W-1:0] word = '0;
  logic pClk, pCsN, pWr, pEn, done, oeN, fullN, emptyN, aeN, afN, mb1N, mb2N, readValid;
  logic [DATA_W-1:0] pData, dataOut, readData;
  logic [OFFSET_W-1:0] flagOffset;
  logic [OFFSET_W-1:0] expOff [4] = '{OFFSET_SEL_00, OFFSET_SEL_01, OFFSET_SEL_10, OFFSET_SEL_11};
  int err_total = 0, comparisons = 0;
  always #10 clk = ~clk;
  port_a_host host (.clk(clk), .start(start), .pulse(pulse), .csN(csN), .wr(wr), .en(en),
    .word(word), .pinClock(pClk), .pinCsN(pCsN), .pinWr(pWr), .pinEn(pEn), .pinData(pData),
    .done(done));
  clocked_fifo_reset_port_a uut (.clk(clk), .reset_n(reset_n), .port_a_clock(pClk),
    .port_a_chip_select_n(pCsN), .port_a_write_read(pWr), .port_a_enable(pEn),
    .flag_select_0(fs0), .flag_select_1(fs1), .port_a_data_in(pData),
    .port_a_data_out(dataOut), .port_a_data_oe_n(oeN), .full_flag_n(fullN),
    .empty_flag_n(emptyN), .almost_empty_n(aeN), .almost_full_n(afN),
    .mailbox1_flag_n(mb1N), .mailbox2_flag_n(mb2N), .flagOffset(flagOffset),
    .readData(readData), .readValid(readValid), .readReady(readReady));
  // Compare and count; four-state inequality so an unknown never matches
  task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Flag levels held by reset, mailbox flags included
  task automatic resetFlags();
    check("full", DATA_W'(fullN), '0);
    check("empty", DATA_W'(emptyN), '0);
    check("almostEmpty", DATA_W'(aeN), '0);
    check("almostFull", DATA_W'(afN), DATA_W'(1'b1));
    check("mailboxes", DATA_W'({mb1N, mb2N}), DATA_W'(2'h3));
  endtask
  // One port A frame through the host model, bounded wait for its end
  task automatic frame(input logic p, c, w, e, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    {start, pulse, csN, wr, en, word} <= {1'b1, p, c, w, e, d};
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk);
    if (n == 40) begin
      err_total++;
      tally_and_finish();
    end
    #1;
  endtask
  // Held reset with the selects set long before release, then the loaded offset
  task automatic doReset(input logic [1:0] s);
    @(posedge clk);
    {reset_n, fs1, fs0} <= {1'b0, s};
    repeat (20) @(posedge clk);
    // The controller gives four port A clock edges while reset is held
    repeat (4) frame(1'b1, 1'b1, 1'b0, 1'b0, '0);
    #1 resetFlags();
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("offset", DATA_W'(flagOffset), DATA_W'(expOff[s]));
  endtask
  initial begin
    // Reset falls at time zero so every flop except the synchroniser stages holds its reset level before the first edge
    reset_n <= 1'b0;
    for (int s = 0; s < 4; s++) doReset(s[1:0]);
    @(posedge clk);
    {fs1, fs0} <= 2'h0;
    repeat (10) @(posedge clk);
    #1 check("offsetHeld", DATA_W'(flagOffset), DATA_W'(OFFSET_SEL_11));
    check("fullBeforeEdges", DATA_W'(fullN), '0);
    frame(1'b1, 1'b1, 1'b0, 1'b0, '0);
    check("fullOneEdge", DATA_W'(fullN), '0);
    frame(1'b1, 1'b1, 1'b0, 1'b0, '0);
    check("fullTwoEdges", DATA_W'(fullN), DATA_W'(1'b1));
    frame(1'b1, 1'b0, 1'b1, 1'b1, 36'h9_a5c3_1e70);
    check("firstWord", readData, 36'h9_a5c3_1e70);
    check("notEmpty", DATA_W'({readValid, emptyN}), DATA_W'(2'h3));
    frame(1'b1, 1'b0, 1'b1, 1'b1, 36'h0_5f0f_e1d2);
    check("twoWordFlags", DATA_W'({fullN, afN, aeN}), DATA_W'(3'h1));
    frame(1'b1, 1'b0, 1'b1, 1'b1, 36'hf_ffff_ffff);
    // Every select and direction pair; only both low drives the bus
    for (int i = 0; i < 4; i++) begin
      frame(1'b0, i[1], i[0], 1'b0, '0);
      repeat (6) @(posedge clk);
      #1 check("driveOff", DATA_W'(oeN), DATA_W'(i != 0));
      if (i == 0) check("driveWord", dataOut, 36'h9_a5c3_1e70);
    end
    @(posedge clk);
    readReady <= 1'b1;
    @(posedge clk);
    #1 check("secondWord", readData, 36'h0_5f0f_e1d2);
    @(posedge clk);
    readReady <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("drained", DATA_W'({readValid, emptyN, fullN}), DATA_W'(3'h1));
    // Reset dropped between clock edges must still force the flags at once
    #7 reset_n = 1'b0;
    #2 resetFlags();
    tally_and_finish();
  end
endmodule // tb
